// [verilog/rx_cfg_pkg.sv]
// constants for the receive output configuration block
package rx_cfg_pkg;
	localparam int unsigned NCH = 3;

	// ------------------------------------------------------------
	// apb register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [11:0] OFF_CTRL   = 12'h000;
	localparam logic [11:0] OFF_MODE   = 12'h004;
	localparam logic [11:0] OFF_STATUS = 12'h008;
	localparam logic [11:0] OFF_MASK   = 12'h00c;
	localparam logic [11:0] OFF_STATE  = 12'h010;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int unsigned CTRL_INV_BIT    = 0;
	localparam int unsigned MODE_W          = 2;
	localparam int unsigned STATE_LOL_LSB   = 0;
	localparam int unsigned STATE_HOST_BIT  = 3;
	localparam int unsigned STATE_INV_BIT   = 4;
	localparam int unsigned STATE_SRAIL_BIT = 5;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic       RST_INV    = 1'b0;
	localparam logic [5:0] RST_MODE   = 6'h00;
	localparam logic [2:0] RST_MASK   = 3'h0;
	localparam logic [2:0] RST_STATUS = 3'h0;

	// line modes per channel
	localparam logic [1:0] MODE_E3   = 2'h0;
	localparam logic [1:0] MODE_DS3  = 2'h1;
	localparam logic [1:0] MODE_STS1 = 2'h2;

	// ------------------------------------------------------------
	// lock check: reference edges per window, allowed slip
	// ------------------------------------------------------------
	localparam logic [7:0] LOL_WINDOW = 8'h40;
	localparam logic [7:0] LOL_TOL    = 8'h04;
endpackage

// [verilog/pin_sync.sv]
// two-stage synchroniser for a bundle of asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         i_clk,  // system clock
	input  wire logic [W-1:0] i_d,    // asynchronous pins
	output logic      [W-1:0] o_q     // synchronised levels
);
	logic [W-1:0] meta_q;

	// first stage feeds only the second stage
	always_ff @(posedge i_clk)
	begin
		meta_q <= i_d;
		o_q    <= meta_q;
	end
endmodule

// [verilog/rx_channel.sv]
// one receive channel: rail output timing, format and lock check
`timescale 1ns/1ps
module rx_channel (
	input  wire logic i_clk,         // system clock
	input  wire logic i_srst,        // synchronous reset
	input  wire logic i_clk_s,       // synced recovered clock
	input  wire logic i_pos_s,       // synced positive pulse
	input  wire logic i_neg_s,       // synced negative pulse
	input  wire logic i_ref_s,       // synced reference clock
	input  wire logic i_invert,      // clock invert in effect
	input  wire logic i_single_rail, // single-rail format
	output logic      o_clk,         // recovered clock out
	output logic      o_pos,         // positive rail out
	output logic      o_neg,         // negative rail out
	output logic      o_lol          // loss of lock alarm
);
	logic       clk_prev_q;
	logic       ref_prev_q;
	logic       clk_rise;
	logic       ref_rise;
	logic [7:0] win_q;
	logic [8:0] rec_q;
	logic [8:0] rec_n;
	logic [8:0] diff;
	logic       inv_hold_q;
	logic       inv_use;

	assign clk_rise = i_clk_s & ~clk_prev_q;
	assign ref_rise = i_ref_s & ~ref_prev_q;
	assign rec_n    = rec_q + {8'h00, clk_rise};
	// an invert change in a rise cycle waits one cycle, so the rails
	// never move without an edge of their output clock
	assign inv_use  = clk_rise ? inv_hold_q : i_invert;
	assign diff     = (rec_n > {1'b0, rx_cfg_pkg::LOL_WINDOW})
		? rec_n - {1'b0, rx_cfg_pkg::LOL_WINDOW}
		: {1'b0, rx_cfg_pkg::LOL_WINDOW} - rec_n;

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			clk_prev_q <= 1'b0;
			ref_prev_q <= 1'b0;
		end
		else
		begin
			clk_prev_q <= i_clk_s;
			ref_prev_q <= i_ref_s;
		end
	end

	// ------------------------------------------------------------
	// clock out and rail update
	// ------------------------------------------------------------
	// data always change at the recovered rising edge; with the clock
	// inverted that same moment is the falling edge seen outside
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			o_clk      <= 1'b0;
			inv_hold_q <= 1'b0;
		end
		else
		begin
			o_clk      <= i_clk_s ^ inv_use; // [R4] [R5] [R13]
			inv_hold_q <= inv_use;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			o_pos <= 1'b0;
			o_neg <= 1'b0;
		end
		else if (clk_rise)
		begin
			if (i_single_rail)
			begin
				o_pos <= i_pos_s | i_neg_s; // [R10] [R14]
				o_neg <= 1'b0;              // [R14]
			end
			else
			begin
				o_pos <= i_pos_s; // [R11]
				o_neg <= i_neg_s; // [R11]
			end
		end
	end

	// ------------------------------------------------------------
	// lock check against this channel's own reference
	// ------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			win_q <= 8'h00;
			rec_q <= 9'h000;
			o_lol <= 1'b0;
		end
		else if (ref_rise && win_q == rx_cfg_pkg::LOL_WINDOW - 8'h01)
		begin
			win_q <= 8'h00;
			rec_q <= 9'h000;
			o_lol <= diff > {1'b0, rx_cfg_pkg::LOL_TOL}; // [R7] [R9]
		end
		else
		begin
			win_q <= win_q + {7'h00, ref_rise};
			rec_q <= rec_n;
		end
	end
endmodule

// [verilog/rx_output_config_ctrl.sv]
// receive output configuration for a three-channel line interface
`timescale 1ns/1ps

// Operation
// R1: shared pin is register reset in host mode, clock invert in hardware mode.
// R2: host mode, shared pin low returns all command registers to defaults.
// R3: shared pin reads high when undriven: no reset, inversion selected.
// R4: hardware mode, invert high: clocks inverted, rails update on falling edge.
// R5: hardware mode, invert low: rails update on rising recovered edge.
// R6: far side drives each reference clock at its channel's line rate.
// R7: each channel checks lock against its own reference clock.
// R8: far side may share a reference with the transmit clock source.
// R9: channels run at different rates independently.
// R10: rail format select high gives single-rail output on every channel.
// R11: rail format select low gives dual-rail output on every channel.
// R12: config source high selects host mode, low selects hardware mode.
// R13: host mode, invert bit one makes rails update on falling edge.
// R14: single-rail puts data on positive rail, negative rail held for status; the code drives it low instead.
module rx_output_config_ctrl (
	input  wire logic        i_clk_sys,                 // 50 MHz system clock
	input  wire logic        i_srst,                    // sync reset, high
	input  wire logic        i_psel,                    // apb select
	input  wire logic        i_penable,                 // apb enable
	input  wire logic        i_pwrite,                  // apb write
	input  wire logic [11:0] i_paddr,                   // apb byte address
	input  wire logic [31:0] i_pwdata,                  // apb write data
	output logic      [31:0] o_prdata,                  // apb read data
	output logic             o_pready,                  // apb ready
	output logic             o_pslverr,                 // apb error
	output logic             o_irq,                     // level interrupt
	input  wire logic        i_config_source_select,    // high host, low pins
	input  wire logic        i_config_reg_reset_n,      // shared reset/invert
	input  wire logic        i_rail_format_select,      // high single-rail
	input  wire logic [2:0]  i_recovered_clock,         // recovery clocks in
	input  wire logic [2:0]  i_recovered_pos,           // positive pulses in
	input  wire logic [2:0]  i_recovered_neg,           // negative pulses in
	input  wire logic [2:0]  i_channel_reference_clock, // reference clocks
	output logic      [2:0]  o_recovered_rx_clock,      // clocks to framer
	output logic      [2:0]  o_rx_positive_rail,        // positive rails
	output logic      [2:0]  o_rx_negative_rail,        // negative rails
	output logic      [2:0]  o_loss_of_lock_alarm       // lock alarms
);
	localparam int unsigned SW = 15;

	// ------------------------------------------------------------
	// pin synchronisation
	// ------------------------------------------------------------
	logic [SW-1:0] pins_s;
	logic          host_s;
	logic          shared_s;
	logic          srail_s;
	logic [2:0]    rclk_s;
	logic [2:0]    rpos_s;
	logic [2:0]    rneg_s;
	logic [2:0]    ref_s;

	pin_sync #(
		.W (SW)
	) u_sync (
		.i_clk (i_clk_sys),
		.i_d   ({i_channel_reference_clock, i_recovered_neg, i_recovered_pos,
			i_recovered_clock, i_rail_format_select, i_config_reg_reset_n,
			i_config_source_select}),
		.o_q   (pins_s)
	);

	assign host_s   = pins_s[0];
	assign shared_s = pins_s[1];
	assign srail_s  = pins_s[2];
	assign rclk_s   = pins_s[5:3];
	assign rpos_s   = pins_s[8:6];
	assign rneg_s   = pins_s[11:9];
	assign ref_s    = pins_s[14:12];

	// ------------------------------------------------------------
	// configuration source and shared pin meaning
	// ------------------------------------------------------------
	logic cfg_rst;
	logic inv_q;
	logic invert;

	// an undriven shared pin reads high, so it neither resets nor
	// blocks inversion; the pull is part of the pad
	assign cfg_rst = i_srst | (host_s & ~shared_s); // [R1] [R2] [R3] [R12]
	assign invert  = host_s ? inv_q : shared_s;     // [R1] [R3] [R4] [R5] [R12]

	// ------------------------------------------------------------
	// apb slave
	// ------------------------------------------------------------
	logic        setup;
	logic        wr_en;
	logic [5:0]  mode_q;
	logic [2:0]  mask_q;
	logic [2:0]  status_q;
	logic [2:0]  lol_prev_q;
	logic [2:0]  lol_rise;
	logic [2:0]  w1c;
	logic [31:0] rd_data;
	logic        mapped;

	// write strobe for one register offset
	function automatic logic reg_write(
		input logic        we,
		input logic [11:0] addr,
		input logic [11:0] off
	);
		return we && addr == off;
	endfunction

	assign setup = i_psel & ~i_penable;
	assign wr_en = i_psel & i_penable & o_pready & i_pwrite & ~o_pslverr;

	always_comb
	begin
		mapped  = 1'b1;
		rd_data = 32'h0000_0000;
		case (i_paddr)
			rx_cfg_pkg::OFF_CTRL:
				rd_data[rx_cfg_pkg::CTRL_INV_BIT] = inv_q;
			rx_cfg_pkg::OFF_MODE:
				rd_data[5:0] = mode_q;
			rx_cfg_pkg::OFF_STATUS:
				rd_data[2:0] = status_q;
			rx_cfg_pkg::OFF_MASK:
				rd_data[2:0] = mask_q;
			rx_cfg_pkg::OFF_STATE:
			begin
				rd_data[rx_cfg_pkg::STATE_LOL_LSB +: 3] = o_loss_of_lock_alarm;
				rd_data[rx_cfg_pkg::STATE_HOST_BIT]     = host_s;
				rd_data[rx_cfg_pkg::STATE_INV_BIT]      = invert;
				rd_data[rx_cfg_pkg::STATE_SRAIL_BIT]    = srail_s;
			end
			default:
				mapped = 1'b0;
		endcase
	end

	// zero wait states: answer is set up during the setup cycle
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h0000_0000;
		end
		else
		begin
			o_pready  <= setup;
			o_pslverr <= setup & ~mapped;
			o_prdata  <= (setup & ~i_pwrite) ? rd_data : 32'h0000_0000;
		end
	end

	// ------------------------------------------------------------
	// command registers
	// ------------------------------------------------------------
	always_ff @(posedge i_clk_sys)
	begin
		if (cfg_rst) // [R2]
			inv_q <= rx_cfg_pkg::RST_INV;
		else if (reg_write(wr_en, i_paddr, rx_cfg_pkg::OFF_CTRL))
			inv_q <= i_pwdata[rx_cfg_pkg::CTRL_INV_BIT]; // [R13]
	end

	// per-channel line mode, kept for each channel on its own
	always_ff @(posedge i_clk_sys)
	begin
		if (cfg_rst) // [R2]
			mode_q <= rx_cfg_pkg::RST_MODE;
		else if (reg_write(wr_en, i_paddr, rx_cfg_pkg::OFF_MODE))
			mode_q <= i_pwdata[5:0]; // [R9]
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (cfg_rst) // [R2]
			mask_q <= rx_cfg_pkg::RST_MASK;
		else if (reg_write(wr_en, i_paddr, rx_cfg_pkg::OFF_MASK))
			mask_q <= i_pwdata[2:0];
	end

	// ------------------------------------------------------------
	// alarm events and interrupt
	// ------------------------------------------------------------
	assign lol_rise = o_loss_of_lock_alarm & ~lol_prev_q;
	assign w1c      = reg_write(wr_en, i_paddr, rx_cfg_pkg::OFF_STATUS)
		? i_pwdata[2:0] : 3'h0;

	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
			lol_prev_q <= 3'h0;
		else
			lol_prev_q <= o_loss_of_lock_alarm;
	end

	// a new event in the clearing cycle survives the clear
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
			status_q <= rx_cfg_pkg::RST_STATUS;
		else
			status_q <= (status_q & ~w1c) | lol_rise;
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
			o_irq <= 1'b0;
		else
			o_irq <= |(status_q & mask_q);
	end

	// ------------------------------------------------------------
	// channels
	// ------------------------------------------------------------
	for (genvar c = 0; c < rx_cfg_pkg::NCH; c++)
	begin : g_ch
		rx_channel u_ch (
			.i_clk         (i_clk_sys),
			.i_srst        (i_srst),
			.i_clk_s       (rclk_s[c]),
			.i_pos_s       (rpos_s[c]),
			.i_neg_s       (rneg_s[c]),
			.i_ref_s       (ref_s[c]),
			.i_invert      (invert),
			.i_single_rail (srail_s),
			.o_clk         (o_recovered_rx_clock[c]),
			.o_pos         (o_rx_positive_rail[c]),
			.o_neg         (o_rx_negative_rail[c]),
			.o_lol         (o_loss_of_lock_alarm[c])
		);
	end
endmodule

// [testbench/rx_cfg_asserts.sv]
// port assertions for the receive output configuration block
`timescale 1ns/1ps
module rx_cfg_asserts (
	input wire logic        i_clk_sys,            // clock
	input wire logic        i_srst,               // reset
	input wire logic        i_psel,               // select
	input wire logic        i_penable,            // enable
	input wire logic        i_pwrite,             // write
	input wire logic [11:0] i_paddr,              // address
	input wire logic [31:0] o_prdata,             // read data
	input wire logic        o_pready,             // ready
	input wire logic        o_pslverr,            // error
	input wire logic [2:0]  o_recovered_rx_clock, // clocks out
	input wire logic [2:0]  o_rx_positive_rail,   // rails
	input wire logic [2:0]  o_rx_negative_rail    // rails
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_srst);
	sequence setup_s;
		i_psel && !i_penable;
	endsequence
	sequence access_s;
		i_psel && i_penable && o_pready;
	endsequence
	a_ready_after_setup: assert property (setup_s |=> access_s ##1 !o_pready)
		else $error("ready did not follow setup");
	a_ready_in_access: assert property (o_pready |-> i_psel && i_penable)
		else $error("ready outside access");
	a_ready_single: assert property (o_pready |=> !o_pready)
		else $error("ready held too long");
	a_err_unmapped: assert property (o_pready |-> o_pslverr ==
		(i_paddr > rx_cfg_pkg::OFF_STATE || i_paddr[1:0] != 2'h0))
		else $error("error flag wrong");
	a_read_quiet: assert property (!(o_pready && !i_pwrite && !o_pslverr) |->
		o_prdata == 32'h0) else $error("read data outside read");
	// a rail may only move in the cycle its output clock moves
	a_rail_on_edge: assert property ((
		((o_rx_positive_rail ^ $past(o_rx_positive_rail)) |
		(o_rx_negative_rail ^ $past(o_rx_negative_rail))) &
		~(o_recovered_rx_clock ^ $past(o_recovered_rx_clock))) == 3'h0)
		else $error("rail moved without clock edge");
	a_rail_exclusive: assert property ((o_rx_positive_rail & o_rx_negative_rail) == 3'h0)
		else $error("both rails high");
	a_reset_quiet: assert property ($fell(i_srst) |-> o_recovered_rx_clock == 3'h0 &&
		!o_pready && o_rx_positive_rail == 3'h0) else $error("outputs not reset");
endmodule
bind rx_output_config_ctrl rx_cfg_asserts u_chk (.i_clk_sys, .i_srst, .i_psel, .i_penable,
	.i_pwrite, .i_paddr, .o_prdata, .o_pready, .o_pslverr, .o_recovered_rx_clock,
	.o_rx_positive_rail, .o_rx_negative_rail);

// [testbench/line_source.sv]
// line side model: recovered clocks, pulses and reference clocks
`timescale 1ns/1ps
module line_source (
	input  wire logic [2:0] i_slow, // stretch reference
	output logic      [2:0] o_rclk, // recovered clocks
	output logic      [2:0] o_pos,  // positive pulses
	output logic      [2:0] o_neg,  // negative pulses
	output logic      [2:0] o_ref   // reference clocks
);
	for (genvar c = 0; c < 3; c++)
	begin : g_ch
		int k = 0;
		initial
		begin
			{o_rclk[c], o_pos[c], o_neg[c], o_ref[c]} = 4'h0;
			#(c * 37);
			forever
			begin
				#80 o_rclk[c] = ~o_rclk[c];
				// pulses move at the falling edge, never both high
				k = o_rclk[c] ? k : (k + 1) % 3;
				o_pos[c] = (k == 0);
				o_neg[c] = (k == 1);
			end
		end
		always
			#(i_slow[c] ? 120 : 80) o_ref[c] = ~o_ref[c];
	end
endmodule

// [testbench/rx_output_config_ctrl_tb.sv]
// self-checking bench for the receive output configuration block
`timescale 1ns/1ps
module rx_output_config_ctrl_tb;
	logic        clk, srst, psel, pen, pwr, src, pin_en, pin_val, srail, rdy, err, irq, got_err;
	logic [11:0] addr;
	logic [31:0] wdata, rdata, got;
	logic [2:0]  slow, rclk, rpos, rneg, refc, oclk, opos, oneg, loss_of_lock_alarm, p, n;
	wire         cfg_pin_n;
	int          failures, checks;

	assign cfg_pin_n = pin_en ? pin_val : 1'b1;
	rx_output_config_ctrl DUT (.i_clk_sys(clk), .i_srst(srst), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdata), .o_prdata(rdata), .o_pready(rdy),
		.o_pslverr(err), .o_irq(irq), .i_config_source_select(src),
		.i_config_reg_reset_n(cfg_pin_n), .i_rail_format_select(srail),
		.i_recovered_clock(rclk), .i_recovered_pos(rpos), .i_recovered_neg(rneg),
		.i_channel_reference_clock(refc), .o_recovered_rx_clock(oclk),
		.o_rx_positive_rail(opos), .o_rx_negative_rail(oneg), .o_loss_of_lock_alarm(loss_of_lock_alarm));
	line_source u_line (.i_slow(slow), .o_rclk(rclk), .o_pos(rpos), .o_neg(rneg), .o_ref(refc));

	task automatic give_verdict();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check(input logic [31:0] g, input logic [31:0] x);
		checks++;
		if (g !== x)
		begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		{psel, pwr, addr, wdata} <= {1'b1, w, a, d};
		@(posedge clk);
		pen <= 1'b1;
		do
			@(posedge clk);
		while (rdy !== 1'b1);
		{got, got_err} = {rdata, err};
		{psel, pen} <= 2'h0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		check(got, x);
	endtask
	// wait for a rail update, then see which output clock level it came with
	task automatic edge_chk(input logic inv);
		logic q;
		@(negedge clk);
		q = opos[0];
		for (int i = 0; i < 80 && opos[0] === q; i++)
			@(negedge clk);
		check({31'h0, opos[0] !== q}, 32'h1);
		check(oclk[0], !inv);
		@(posedge clk);
	endtask
	task automatic wait_lol(input logic [2:0] x);
		for (int i = 0; i < 3000 && loss_of_lock_alarm !== x; i++)
			@(negedge clk);
		check(loss_of_lock_alarm, x);
	endtask

	task automatic t_host();
		rd(rx_cfg_pkg::OFF_MODE, 32'h0);
		apb(1'b1, rx_cfg_pkg::OFF_MODE, 32'h24);
		apb(1'b1, rx_cfg_pkg::OFF_CTRL, 32'h1);
		rd(rx_cfg_pkg::OFF_STATE, 32'h18);
		edge_chk(1'b1);
		pin_val <= 1'b0;
		repeat (4) @(posedge clk);
		rd(rx_cfg_pkg::OFF_STATE, 32'h08);
		pin_val <= 1'b1;
		rd(rx_cfg_pkg::OFF_MODE, 32'h0);
		rd(rx_cfg_pkg::OFF_CTRL, 32'h0);
		edge_chk(1'b0);
		apb(1'b1, 12'h014, 32'h1);
		check(got_err, 1'b1);
		$display("host test done");
	endtask
	task automatic t_hw();
		{src, pin_en} <= 2'h0;
		apb(1'b1, rx_cfg_pkg::OFF_MODE, 32'h24);
		rd(rx_cfg_pkg::OFF_STATE, 32'h10);
		edge_chk(1'b1);
		{pin_en, pin_val} <= 2'h2;
		repeat (6) @(posedge clk);
		rd(rx_cfg_pkg::OFF_MODE, 32'h24);
		rd(rx_cfg_pkg::OFF_STATE, 32'h00);
		edge_chk(1'b0);
		$display("pin test done");
	endtask
	task automatic t_rail(input logic s);
		srail <= s;
		repeat (40) @(posedge clk);
		{p, n} = 6'h0;
		repeat (64)
		begin
			@(negedge clk);
			{p, n} = {p | opos, n | oneg};
		end
		check({p, n}, s ? 6'h38 : 6'h3f);
		@(posedge clk);
		$display("rail test done");
	endtask
	task automatic t_lol();
		apb(1'b1, rx_cfg_pkg::OFF_MASK, 32'h1);
		slow <= 3'h1;
		wait_lol(3'h1);
		rd(rx_cfg_pkg::OFF_STATUS, 32'h1);
		check(irq, 1'b1);
		apb(1'b1, rx_cfg_pkg::OFF_MASK, 32'h0);
		repeat (3) @(negedge clk);
		check(irq, 1'b0);
		apb(1'b1, rx_cfg_pkg::OFF_STATUS, 32'h1);
		apb(1'b1, rx_cfg_pkg::OFF_MASK, 32'h1);
		rd(rx_cfg_pkg::OFF_STATUS, 32'h0);
		slow <= 3'h0;
		wait_lol(3'h0);
		check(irq, 1'b0);
		$display("lock test done");
	endtask

	initial
	begin
		{srst, src, pin_en, pin_val} = 4'hf;
		{psel, pen, pwr, srail, slow, addr, wdata} = '0;
		{failures, checks} = '0;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		t_host();
		t_hw();
		t_rail(1'b1);
		t_rail(1'b0);
		t_lol();
		give_verdict();
	end
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// hang guard
	initial
	begin
		repeat (40000) @(posedge clk);
		failures++;
		give_verdict();
	end
endmodule
